//--- rtl/rsi_reset_state_initializer.sv
`timescale 1ns/10ps
`default_nettype none
module rsi_reset_state_initializer #(
  parameter int unsigned ADDR_W = 4
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic por_event_i,
  input wire logic bor_event_i,
  input wire logic clear_pin_event_i,
  input wire logic watchdog_event_i,
  input wire logic irq_wake_event_i,
  input wire logic sleeping_i,
  input wire logic global_irq_enable_i,
  input wire logic [rsi_pkg::PC_W-1:0] pc_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [7:0] rdata_o,
  output logic pc_load_o,
  output logic [rsi_pkg::PC_W-1:0] pc_o,
  output logic [7:0] core_status_o,
  output logic [1:0] power_control_o,
  output logic [7:0] option_o,
  output logic [7:0] port_a_direction_o,
  output logic [7:0] port_b_direction_o,
  output logic [7:0] port_c_direction_o,
  output logic [7:0] port_d_direction_o,
  output logic [7:0] port_e_direction_o,
  output logic [7:0] timer_two_period_o,
  output logic irq_o
);
  typedef struct packed {
    logic [7:0] status;
    logic [1:0] pwr;
    logic [7:0] option;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
    logic [7:0] dir_d;
    logic [7:0] dir_e;
    logic [7:0] t2per;
    logic [7:0] transmit_status;
    logic [7:0] conv;
    logic [7:0] flags1;
    logic [7:0] en1;
    logic [rsi_pkg::EVT_W-1:0] evt;
    logic [rsi_pkg::EVT_W-1:0] mask;
    logic pc_load;
    logic [rsi_pkg::PC_W-1:0] pc;
    logic [7:0] rdata;
    logic [rsi_pkg::EVT_W-1:0] wake_seen;
  } rsi_state_s;

  rsi_state_s state_q;
  rsi_state_s state_d;
  rsi_pkg::rsi_cause_e cause;

  // Fixed priority picks one cause even when detectors overlap
  always_comb begin
    if (por_event_i) begin
      cause = rsi_pkg::RSI_POR;
    end else if (bor_event_i) begin
      cause = rsi_pkg::RSI_BOR;
    end else if (clear_pin_event_i) begin
      cause = sleeping_i ? rsi_pkg::RSI_CLR_SLEEP : rsi_pkg::RSI_CLR_RUN;
    end else if (watchdog_event_i) begin
      cause = sleeping_i ? rsi_pkg::RSI_WDT_WAKE : rsi_pkg::RSI_WDT_RST;
    end else if (irq_wake_event_i && sleeping_i) begin
      cause = rsi_pkg::RSI_IRQ_WAKE;
    end else begin
      cause = rsi_pkg::RSI_NONE;
    end
  end

  function automatic rsi_state_s full_reset(input rsi_state_s s);
    rsi_state_s r;
    r = s;
    r.pc_load = 1'b1;
    r.pc = rsi_pkg::RESET_VECTOR;
    r.option = rsi_pkg::ALL_ONES;
    r.dir_a = rsi_pkg::ALL_ONES;
    r.dir_b = rsi_pkg::ALL_ONES;
    r.dir_c = rsi_pkg::ALL_ONES;
    r.dir_d = rsi_pkg::ALL_ONES;
    r.dir_e = rsi_pkg::PORT_E_DIR_RESET;
    r.t2per = rsi_pkg::ALL_ONES;
    r.transmit_status = rsi_pkg::TX_STATUS_RESET;
    r.conv = 8'h00;
    r.flags1 = 8'h00;
    r.en1 = 8'h00;
    return r;
  endfunction

  logic [rsi_pkg::EVT_W-1:0] evt_set;
  logic [rsi_pkg::PC_W-1:0] next_pc;

  always_comb begin
    state_d = state_q;
    state_d.pc_load = 1'b0;
    state_d.rdata = 8'h00;
    evt_set = '0;
    next_pc = pc_i + rsi_pkg::PC_W'(1);
    // Software access first; a cause in the same cycle overrides only the fields it loads
    if (write_i) begin
      unique case (addr_i)
        rsi_pkg::A_STATUS: state_d.status = wdata_i;
        rsi_pkg::A_PWRCTL: state_d.pwr = wdata_i[1:0];
        rsi_pkg::A_OPTION: state_d.option = wdata_i;
        rsi_pkg::A_DIR_A: state_d.dir_a = wdata_i;
        rsi_pkg::A_DIR_B: state_d.dir_b = wdata_i;
        rsi_pkg::A_DIR_C: state_d.dir_c = wdata_i;
        rsi_pkg::A_DIR_D: state_d.dir_d = wdata_i;
        rsi_pkg::A_DIR_E: state_d.dir_e = wdata_i & rsi_pkg::PORT_E_DIR_MASK;
        rsi_pkg::A_T2PER: state_d.t2per = wdata_i;
        rsi_pkg::A_TRANSMIT_STATUS: state_d.transmit_status = wdata_i & rsi_pkg::TX_STATUS_MASK;
        rsi_pkg::A_CONV: state_d.conv = wdata_i & rsi_pkg::CONV_CTRL_MASK;
        rsi_pkg::A_FLAGS1: state_d.flags1 = wdata_i & rsi_pkg::FLAGS_ONE_MASK;
        rsi_pkg::A_ENABLES1: state_d.en1 = wdata_i & rsi_pkg::FLAGS_ONE_MASK;
        rsi_pkg::A_EVT: state_d.evt = state_q.evt & ~wdata_i[rsi_pkg::EVT_W-1:0];
        rsi_pkg::A_MASK: state_d.mask = wdata_i[rsi_pkg::EVT_W-1:0];
        default: state_d.wake_seen = '0;
      endcase
    end
    if (read_i) begin
      unique case (addr_i)
        rsi_pkg::A_STATUS: state_d.rdata = state_q.status;
        rsi_pkg::A_PWRCTL: state_d.rdata = {6'h00, state_q.pwr};
        rsi_pkg::A_OPTION: state_d.rdata = state_q.option;
        rsi_pkg::A_DIR_A: state_d.rdata = state_q.dir_a;
        rsi_pkg::A_DIR_B: state_d.rdata = state_q.dir_b;
        rsi_pkg::A_DIR_C: state_d.rdata = state_q.dir_c;
        rsi_pkg::A_DIR_D: state_d.rdata = state_q.dir_d;
        rsi_pkg::A_DIR_E: state_d.rdata = state_q.dir_e;
        rsi_pkg::A_T2PER: state_d.rdata = state_q.t2per;
        rsi_pkg::A_TRANSMIT_STATUS: state_d.rdata = state_q.transmit_status;
        rsi_pkg::A_CONV: state_d.rdata = state_q.conv;
        rsi_pkg::A_FLAGS1: state_d.rdata = state_q.flags1;
        rsi_pkg::A_ENABLES1: state_d.rdata = state_q.en1;
        rsi_pkg::A_EVT: state_d.rdata = {1'b0, state_q.evt};
        rsi_pkg::A_MASK: state_d.rdata = {1'b0, state_q.mask};
        default: state_d.rdata = state_q.pc[7:0];
      endcase
    end
    unique case (cause)
      rsi_pkg::RSI_POR: begin
        state_d = full_reset(state_d);
        state_d.status = rsi_pkg::ST_POR_VALUE | (state_q.status & rsi_pkg::ST_KEEP_LOW3);
        state_d.pwr[rsi_pkg::PC_POR] = 1'b0;
        evt_set[0] = 1'b1;
      end
      rsi_pkg::RSI_BOR: begin
        state_d = full_reset(state_d);
        state_d.status = rsi_pkg::ST_POR_VALUE | (state_q.status & rsi_pkg::ST_KEEP_LOW3);
        state_d.pwr[rsi_pkg::PC_BOR] = 1'b0;
        evt_set[1] = 1'b1;
      end
      rsi_pkg::RSI_CLR_RUN: begin
        state_d = full_reset(state_d);
        state_d.status = state_q.status & rsi_pkg::ST_KEEP_LOW5;
        state_d.pwr = state_q.pwr;
        evt_set[2] = 1'b1;
      end
      rsi_pkg::RSI_CLR_SLEEP: begin
        state_d = full_reset(state_d);
        state_d.status = state_q.status & rsi_pkg::ST_KEEP_LOW3;
        state_d.status[rsi_pkg::ST_TO] = 1'b1;
        state_d.pwr = state_q.pwr;
        evt_set[3] = 1'b1;
      end
      rsi_pkg::RSI_WDT_RST: begin
        state_d = full_reset(state_d);
        state_d.status = state_q.status & rsi_pkg::ST_KEEP_LOW3;
        state_d.status[rsi_pkg::ST_PD] = 1'b1;
        state_d.pwr = state_q.pwr;
        evt_set[4] = 1'b1;
      end
      rsi_pkg::RSI_WDT_WAKE: begin
        // Resumption, not a reset: only the counter, two status flags and event bit 5 (with its wake_seen copy) move
        state_d.pc_load = 1'b1;
        state_d.pc = next_pc;
        state_d.status[rsi_pkg::ST_TO] = 1'b0;
        state_d.status[rsi_pkg::ST_PD] = 1'b0;
        evt_set[5] = 1'b1;
      end
      rsi_pkg::RSI_IRQ_WAKE: begin
        state_d.pc_load = 1'b1;
        state_d.pc = global_irq_enable_i ? rsi_pkg::IRQ_VECTOR : next_pc;
        state_d.status[rsi_pkg::ST_TO] = 1'b1;
        state_d.status[rsi_pkg::ST_PD] = 1'b0;
        evt_set[6] = 1'b1;
      end
      rsi_pkg::RSI_NONE: begin
        state_d.pc_load = 1'b0;
      end
    endcase
    // Set wins over a clear in the same cycle
    state_d.evt = state_d.evt | evt_set;
    state_d.wake_seen = state_d.wake_seen | evt_set;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rdata_o = state_q.rdata;
  assign pc_load_o = state_q.pc_load;
  assign pc_o = state_q.pc;
  assign core_status_o = state_q.status;
  assign power_control_o = state_q.pwr;
  assign option_o = state_q.option;
  assign port_a_direction_o = state_q.dir_a;
  assign port_b_direction_o = state_q.dir_b;
  assign port_c_direction_o = state_q.dir_c;
  assign port_d_direction_o = state_q.dir_d;
  assign port_e_direction_o = state_q.dir_e;
  assign timer_two_period_o = state_q.t2per;
  assign irq_o = |(state_q.evt & state_q.mask);

  reset_pc_zero_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (cause inside {rsi_pkg::RSI_POR, rsi_pkg::RSI_BOR, rsi_pkg::RSI_CLR_RUN,
      rsi_pkg::RSI_WDT_RST}) |=> (pc_load_o && pc_o == rsi_pkg::RESET_VECTOR))
    else $error("reset did not load zero");
  clr_run_status_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause == rsi_pkg::RSI_CLR_RUN |=>
      core_status_o == ($past(core_status_o) & rsi_pkg::ST_KEEP_LOW5)
      && power_control_o == $past(power_control_o))
    else $error("clear-pin run status wrong");
  clr_sleep_flags_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause == rsi_pkg::RSI_CLR_SLEEP |=> core_status_o[7:3] == 5'h02)
    else $error("clear-pin sleep status wrong");
  irq_wake_pc_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause == rsi_pkg::RSI_IRQ_WAKE && !global_irq_enable_i |=>
      pc_o == $past(pc_i) + rsi_pkg::PC_W'(1) && core_status_o[4:3] == 2'b10)
    else $error("interrupt wake continuation wrong");
  irq_vector_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause == rsi_pkg::RSI_IRQ_WAKE && global_irq_enable_i |=> pc_o == rsi_pkg::IRQ_VECTOR)
    else $error("interrupt vector not loaded");
  por_flag_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause != rsi_pkg::RSI_POR && !(write_i && addr_i == rsi_pkg::A_PWRCTL) |=>
      power_control_o[rsi_pkg::PC_POR] == $past(power_control_o[rsi_pkg::PC_POR]))
    else $error("power-on flag changed");
  wdt_wake_keep_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause == rsi_pkg::RSI_WDT_WAKE && !write_i |=>
      option_o == $past(option_o) && timer_two_period_o == $past(timer_two_period_o)
      && core_status_o[4:3] == 2'b00)
    else $error("watchdog wake disturbed registers");
  reset_dirs_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause == rsi_pkg::RSI_WDT_RST |=> port_e_direction_o == rsi_pkg::PORT_E_DIR_RESET
      && port_a_direction_o == rsi_pkg::ALL_ONES && core_status_o[7:3] == 5'h01)
    else $error("reset directions wrong");
  wake_flag_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause inside {rsi_pkg::RSI_WDT_WAKE, rsi_pkg::RSI_IRQ_WAKE} |=> state_q.evt != '0)
    else $error("wake cause not recorded");
  por_seen_c: cover property (@(posedge clock_i) cause == rsi_pkg::RSI_POR);
  irq_vec_c: cover property (@(posedge clock_i)
    cause == rsi_pkg::RSI_IRQ_WAKE && global_irq_enable_i);
  wdt_wake_c: cover property (@(posedge clock_i) cause == rsi_pkg::RSI_WDT_WAKE);
  irq_out_c: cover property (@(posedge clock_i) irq_o);
  wdt_rst_c: cover property (@(posedge clock_i) cause == rsi_pkg::RSI_WDT_RST);

  // Cause-specific status, power-control and counter patterns
  por_status_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause == rsi_pkg::RSI_POR |=>
      (core_status_o & ~rsi_pkg::ST_KEEP_LOW3) == rsi_pkg::ST_POR_VALUE
      && !power_control_o[rsi_pkg::PC_POR])
    else $error("power-on status wrong");

  bor_flags_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause == rsi_pkg::RSI_BOR |=>
      !power_control_o[rsi_pkg::PC_BOR]
      && power_control_o[rsi_pkg::PC_POR] == $past(power_control_o[rsi_pkg::PC_POR]))
    else $error("brown-out flags wrong");

  wdt_rst_status_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause == rsi_pkg::RSI_WDT_RST |=>
      core_status_o[7:4] == 4'h0 && core_status_o[rsi_pkg::ST_PD]
      && power_control_o == $past(power_control_o))
    else $error("watchdog reset status wrong");

  wdt_wake_pc_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause == rsi_pkg::RSI_WDT_WAKE |=>
      pc_load_o && pc_o == $past(pc_i) + rsi_pkg::PC_W'(1))
    else $error("watchdog wake continuation wrong");

  clr_sleep_keep_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause == rsi_pkg::RSI_CLR_SLEEP |=>
      power_control_o == $past(power_control_o)
      && core_status_o[2:0] == $past(core_status_o[2:0]))
    else $error("clear-pin sleep kept bits wrong");

  // A write in the same cycle may move a register, so wake checks skip it
  wake_dirs_keep_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause inside {rsi_pkg::RSI_WDT_WAKE, rsi_pkg::RSI_IRQ_WAKE} && !write_i |=>
      port_a_direction_o == $past(port_a_direction_o)
      && port_b_direction_o == $past(port_b_direction_o)
      && port_e_direction_o == $past(port_e_direction_o))
    else $error("wake changed direction registers");

  wake_status_keep_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause inside {rsi_pkg::RSI_WDT_WAKE, rsi_pkg::RSI_IRQ_WAKE} && !write_i |=>
      core_status_o[7:5] == $past(core_status_o[7:5])
      && core_status_o[2:0] == $past(core_status_o[2:0])
      && power_control_o == $past(power_control_o))
    else $error("wake changed kept status bits");

  reset_others_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause inside {rsi_pkg::RSI_POR, rsi_pkg::RSI_BOR, rsi_pkg::RSI_CLR_RUN,
      rsi_pkg::RSI_CLR_SLEEP} |=>
      option_o == rsi_pkg::ALL_ONES && timer_two_period_o == rsi_pkg::ALL_ONES
      && port_d_direction_o == rsi_pkg::ALL_ONES)
    else $error("reset register values wrong");

  no_cause_load_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause == rsi_pkg::RSI_NONE |=> !pc_load_o)
    else $error("counter loaded without a cause");

  // Read data is zero outside its one cycle so a stale byte is never seen
  rdata_idle_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !read_i |=> rdata_o == 8'h00)
    else $error("read data not idle");

  unimpl_zero_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (state_q.transmit_status & ~rsi_pkg::TX_STATUS_MASK) == 8'h00
      && (state_q.conv & ~rsi_pkg::CONV_CTRL_MASK) == 8'h00
      && (state_q.flags1 & ~rsi_pkg::FLAGS_ONE_MASK) == 8'h00
      && (state_q.en1 & ~rsi_pkg::FLAGS_ONE_MASK) == 8'h00)
    else $error("unimplemented bit set");

  // Set wins even against a clear written in the same cycle
  irq_wake_evt_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause == rsi_pkg::RSI_IRQ_WAKE |=> state_q.evt[6])
    else $error("interrupt wake event lost");

  wdt_wake_evt_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    cause == rsi_pkg::RSI_WDT_WAKE |=> state_q.evt[5])
    else $error("watchdog wake event lost");
endmodule
`default_nettype wire

//--- rtl/rsi_pkg.sv
// Summary of operation
// - Power-on, brown-out, clear-pin and watchdog resets load program counter with zero.
// - Clear-pin reset while running clears status 7..5, keeps other bits.
// - Clear-pin reset asleep: status 7..5 cleared, timeout set, powerdown cleared.
// - Interrupt wake-up: next address, timeout set, powerdown cleared, rest kept.
// - Interrupt wake-up with global enable set loads the interrupt vector.
// - Power-on: status 0001_1xxx, power-on flag clear; brown-out clears brown-out flag.
// - Watchdog reset clears status 7..4, sets powerdown; watchdog wake clears both flags.
// - Resets set option, port A-D directions, timer-two period to ones; port E 0000_0111.
// - A wake-up leaves at least one interrupt flag set showing its cause.
// - Unimplemented register bits always read as zero.
// - Of the causes only power-on reset clears the power-on flag; a software write sets or clears it.
// - Watchdog wake-up does not drive registers to their reset state.
package rsi_pkg;
  localparam int unsigned PC_W = 13;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] PORT_E_DIR_RESET = 8'h07;
  localparam logic [7:0] PORT_E_DIR_MASK = 8'hF7;
  localparam logic [7:0] TX_STATUS_MASK = 8'hF7;
  localparam logic [7:0] TX_STATUS_RESET = 8'h02;
  localparam logic [7:0] CONV_CTRL_MASK = 8'hFD;
  localparam logic [7:0] FLAGS_ONE_MASK = 8'h77;
  // Status field positions
  localparam int unsigned ST_TO = 4;
  localparam int unsigned ST_PD = 3;
  localparam logic [7:0] ST_POR_VALUE = 8'h18;
  localparam logic [7:0] ST_KEEP_LOW3 = 8'h07;
  localparam logic [7:0] ST_KEEP_LOW5 = 8'h1F;
  localparam logic [7:0] ST_KEEP_TOP3 = 8'hE0;
  // Power control field positions
  localparam int unsigned PC_POR = 1;
  localparam int unsigned PC_BOR = 0;
  // Register indices
  localparam logic [3:0] A_STATUS = 4'h0;
  localparam logic [3:0] A_PWRCTL = 4'h1;
  localparam logic [3:0] A_OPTION = 4'h2;
  localparam logic [3:0] A_DIR_A = 4'h3;
  localparam logic [3:0] A_DIR_B = 4'h4;
  localparam logic [3:0] A_DIR_C = 4'h5;
  localparam logic [3:0] A_DIR_D = 4'h6;
  localparam logic [3:0] A_DIR_E = 4'h7;
  localparam logic [3:0] A_T2PER = 4'h8;
  localparam logic [3:0] A_TRANSMIT_STATUS = 4'h9;
  localparam logic [3:0] A_CONV = 4'hA;
  localparam logic [3:0] A_FLAGS1 = 4'hB;
  localparam logic [3:0] A_ENABLES1 = 4'hC;
  localparam logic [3:0] A_EVT = 4'hD;
  localparam logic [3:0] A_MASK = 4'hE;
  localparam logic [3:0] A_PCLO = 4'hF;
  // Event bits: 0 por,1 bor,2 clr run,3 clr sleep,4 wdt rst,5 wdt wake,6 irq wake
  localparam int unsigned EVT_W = 7;
  typedef enum logic [2:0] {
    RSI_NONE, RSI_POR, RSI_BOR, RSI_CLR_RUN, RSI_CLR_SLEEP, RSI_WDT_RST, RSI_WDT_WAKE,
    RSI_IRQ_WAKE
  } rsi_cause_e;
endpackage

//--- sim/test_rsi_reset_state_initializer.sv
`timescale 1ns/10ps
`default_nettype none
module test_rsi_reset_state_initializer;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [4:0] cause = 5'h00;
  logic sleeping = 1'b0;
  logic global_irq_enable = 1'b0;
  logic [12:0] pc_in = 13'h0000;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, status, opt, dir_a, dir_b, dir_c, dir_d, dir_e, t2per, old_st, d;
  logic [1:0] pwr, old_pw;
  logic [12:0] pc_out;
  logic pc_load, irq_out;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;

  rsi_reset_state_initializer dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .por_event_i(cause[4]), .bor_event_i(cause[3]), .clear_pin_event_i(cause[2]),
    .watchdog_event_i(cause[1]), .irq_wake_event_i(cause[0]), .sleeping_i(sleeping),
    .global_irq_enable_i(global_irq_enable), .pc_i(pc_in), .addr_i(addr), .wdata_i(wdata),
    .write_i(wr), .read_i(rd), .rdata_o(rdata), .pc_load_o(pc_load), .pc_o(pc_out),
    .core_status_o(status), .power_control_o(pwr), .option_o(opt),
    .port_a_direction_o(dir_a), .port_b_direction_o(dir_b), .port_c_direction_o(dir_c),
    .port_d_direction_o(dir_d), .port_e_direction_o(dir_e),
    .timer_two_period_o(t2per), .irq_o(irq_out));

  always #20 clock_i = ~clock_i;

  // Whole run needs well under a thousand cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Old values are sampled before the pulse so kept bits can be predicted
  task automatic fire(input logic [4:0] m);
    old_st = status;
    old_pw = pwr;
    @(posedge clock_i);
    cause <= m;
    @(posedge clock_i);
    cause <= 5'h00;
    #1;
  endtask

  task automatic chk_state(input logic [7:0] st, input logic [1:0] pw, input logic [12:0] pc);
    chk({15'h0000, pc_load}, 16'h0001);
    chk({3'h0, pc_out}, {3'h0, pc});
    chk({8'h00, status}, {8'h00, st});
    chk({14'h0000, pwr}, {14'h0000, pw});
  endtask

  task automatic chk_defaults();
    chk({opt, dir_a}, 16'hFFFF);
    chk({dir_b, dir_c}, 16'hFFFF);
    chk({dir_d, t2per}, 16'hFFFF);
    chk({8'h00, dir_e}, 16'h0007);
  endtask

  task automatic t_por();
    fire(5'h10);
    chk_state(8'h18 | (old_st & 8'h07), {1'b0, old_pw[0]}, 13'h0000);
    chk_defaults();
    @(posedge clock_i);
    #1 chk({15'h0000, pc_load}, 16'h0000);
  endtask

  task automatic t_bor();
    reg_wr(rsi_pkg::A_PWRCTL, 8'h03);
    reg_wr(rsi_pkg::A_OPTION, 8'h12);
    fire(5'h08);
    chk_state(8'h18 | (old_st & 8'h07), {old_pw[1], 1'b0}, 13'h0000);
    chk_defaults();
  endtask

  task automatic t_clear_pin();
    reg_wr(rsi_pkg::A_STATUS, 8'hFF);
    fire(5'h04);
    chk_state(old_st & 8'h1F, old_pw, 13'h0000);
    sleeping <= 1'b1;
    fire(5'h04);
    chk_state((old_st & 8'h07) | 8'h10, old_pw, 13'h0000);
    sleeping <= 1'b0;
  endtask

  task automatic t_watchdog();
    reg_wr(rsi_pkg::A_DIR_B, 8'h00);
    fire(5'h02);
    chk_state((old_st & 8'h07) | 8'h08, old_pw, 13'h0000);
    chk_defaults();
    reg_wr(rsi_pkg::A_OPTION, 8'h5A);
    reg_wr(rsi_pkg::A_DIR_A, 8'h3C);
    sleeping <= 1'b1;
    pc_in <= 13'h0ABC;
    fire(5'h02);
    chk_state(old_st & 8'hE7, old_pw, 13'h0ABD);
    chk({opt, dir_a}, 16'h5A3C);
    chk({8'h00, t2per}, 16'h00FF);
    reg_rd(rsi_pkg::A_EVT, d);
    chk({8'h00, d & 8'h20}, 16'h0020);
  endtask

  task automatic t_irq_wake();
    pc_in <= 13'h0123;
    fire(5'h01);
    chk_state((old_st & 8'hE7) | 8'h10, old_pw, 13'h0124);
    global_irq_enable <= 1'b1;
    fire(5'h01);
    chk_state((old_st & 8'hE7) | 8'h10, old_pw, 13'h0004);
    reg_rd(rsi_pkg::A_EVT, d);
    chk({8'h00, d & 8'h40}, 16'h0040);
    reg_rd(rsi_pkg::A_PCLO, d);
    chk({8'h00, d}, 16'h0004);
    sleeping <= 1'b0;
    fire(5'h01);
    chk({15'h0000, pc_load}, 16'h0000);
    chk({8'h00, status}, {8'h00, old_st});
  endtask

  task automatic t_irq_line();
    reg_wr(rsi_pkg::A_MASK, 8'h40);
    chk({15'h0000, irq_out}, 16'h0001);
    reg_wr(rsi_pkg::A_MASK, 8'h00);
    chk({15'h0000, irq_out}, 16'h0000);
    reg_wr(rsi_pkg::A_MASK, 8'h40);
    reg_wr(rsi_pkg::A_EVT, 8'h40);
    chk({15'h0000, irq_out}, 16'h0000);
    reg_rd(rsi_pkg::A_EVT, d);
    chk({8'h00, d & 8'h40}, 16'h0000);
  endtask

  // Masked bits of transmit status, conversion, port E direction, flag and enable registers read back as zero
  task automatic t_unimplemented();
    logic [3:0] a [5] = '{rsi_pkg::A_TRANSMIT_STATUS, rsi_pkg::A_CONV, rsi_pkg::A_DIR_E,
                          rsi_pkg::A_FLAGS1, rsi_pkg::A_ENABLES1};
    logic [7:0] w [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h7F};
    logic [7:0] e [5] = '{8'hF7, 8'hFD, 8'hF7, 8'h77, 8'h77};
    for (int i = 0; i < 5; i++) begin
      reg_wr(a[i], w[i]);
      reg_rd(a[i], d);
      chk({8'h00, d}, {8'h00, e[i]});
    end
  endtask

  // Three causes in one cycle: power-on must win
  task automatic t_priority();
    sleeping <= 1'b1;
    reg_wr(rsi_pkg::A_PWRCTL, 8'h03);
    fire(5'h13);
    chk_state(8'h18 | (old_st & 8'h07), {1'b0, old_pw[0]}, 13'h0000);
    sleeping <= 1'b0;
  endtask

  initial begin
    repeat (6) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_por();
    t_bor();
    t_clear_pin();
    t_watchdog();
    t_irq_wake();
    t_irq_line();
    t_unimplemented();
    t_priority();
    report_and_stop();
  end
endmodule
`default_nettype wire
